// >>> hdl/adccs_consts.svh
`ifndef ADCCS_CONSTS_SVH
`define ADCCS_CONSTS_SVH

// register byte addresses on the apb bus
`define ADCCS_ADDR_CTRL_A 12'h000
`define ADCCS_ADDR_PORT_REF 12'h004
`define ADCCS_ADDR_FMT 12'h008
`define ADCCS_ADDR_RES_HIGH 12'h00c
`define ADCCS_ADDR_RES_LOW 12'h010
`define ADCCS_ADDR_FLAG 12'h014

// field positions
`define ADCCS_CTL_EN_BIT 0
`define ADCCS_CTL_GO_BIT 1
`define ADCCS_CTL_CHAN_LSB 2
`define ADCCS_CFG_PCFG_LSB 0
`define ADCCS_CFG_POSREF_BIT 4
`define ADCCS_CFG_NEGREF_BIT 5
`define ADCCS_FMT_CS_LSB 0
`define ADCCS_FMT_ACQ_LSB 3
`define ADCCS_FMT_JUST_BIT 7
`define ADCCS_FLAG_DONE_BIT 0

// reset values
`define ADCCS_CTRL_A_RST 8'h00
`define ADCCS_PORT_REF_RST 6'h00
`define ADCCS_FMT_JUST_RST 1'h0
`define ADCCS_FMT_ACQ_RST 3'h0
`define ADCCS_FMT_CS_RST 3'h0

// timing
`define ADCCS_CLK_PERIOD_NS 50
`define ADCCS_TCY_NS 200
`define ADCCS_RC_DLY_CLKS ((`ADCCS_TCY_NS + `ADCCS_CLK_PERIOD_NS - 1) / `ADCCS_CLK_PERIOD_NS)
`define ADCCS_CONV_TADS 11
`define ADCCS_GAP_TADS 2

`endif

// >>> hdl/adccs_pkg.sv
package adccs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RC_DLY,
    ST_ACQ,
    ST_CONV,
    ST_GAP
  } adccs_state_e;

  typedef struct packed {
    logic [9:0] code;
    logic [3:0] cnt;
    logic busy;
    logic done;
  } adccs_sar_s;

  typedef struct packed {
    adccs_state_e state;
    logic en;
    logic go;
    logic [3:0] chan;
    logic [5:0] port_ref;
    logic just;
    logic [2:0] acq;
    logic [2:0] cs;
    logic flag;
    logic [5:0] div_cnt;
    logic [4:0] tad_cnt;
    logic [2:0] dly_cnt;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic sar_start;
    logic [15:0] pin_analog;
    logic sample_on;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adccs_top_s;

endpackage

// >>> hdl/adccs_sar.sv
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"

module adccs_sar (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tad_tick,
  input wire logic start,
  input wire logic abort,
  input wire logic comp_above,
  output logic [9:0] trial_code,
  output logic done
);

  adccs_pkg::adccs_sar_s q, d;

  // first period settles the hold, then one bit per period from the msb down
  always_comb begin
    logic [3:0] bidx;
    bidx = 4'(10 - q.cnt);
    d = q;
    d.done = 1'b0;
    if (abort) begin
      d.busy = 1'b0;
    end else if (start) begin
      d.busy = 1'b1;
      d.cnt = 4'h0;
      d.code = 10'h000;
    end else if (q.busy && tad_tick) begin
      if (q.cnt == 4'h0) begin
        d.code[9] = 1'b1;
      end else begin
        if (!comp_above) begin
          d.code[bidx] = 1'b0; // see RL9
        end
        if (bidx != 4'h0) begin
          d.code[bidx - 4'h1] = 1'b1;
        end
      end
      if (q.cnt == 4'(`ADCCS_CONV_TADS - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1; // see RL18
      end
      d.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trial_code = q.code;
  assign done = q.done;

endmodule
`default_nettype wire

// >>> hdl/adccs_top.sv
// How it works
// RL1 - negative reference bit 5: 1 takes AN2 pin, 0 analog ground
// RL2 - positive reference bit 4: 1 takes AN3 pin, 0 analog supply
// RL3 - port code 0 all analog; code k gives analog only below 15 minus k
// RL4 - format bit 7: 1 right-justified result, 0 left-justified
// RL5 - acquisition codes give 0,2,4,6,8,12,16,20 converter periods
// RL6 - clock codes divide by 2,8,32,4,16,64; x11 uses internal rc
// RL7 - rc source adds one instruction cycle before converter clock starts
// RL8 - conversion keeps running in sleep only on rc clock
// RL9 - result built by successive approximation on the held sample
// RL10 - on completion load result, clear busy bit, set done flag
// RL11 - reset restores control registers, turns converter off, aborts conversion
// RL12 - power-on reset leaves result pair untouched
// RL13 - nonzero acquisition length samples that long after start, then converts
// RL14 - software configures, enables, starts, waits, then reads result
// RL15 - at least two converter periods between conversion end and acquisition
// RL16 - unimplemented control bits read zero
// RL17 - control a: channel bits 5-2, start/busy bit 1, enable bit 0
// RL18 - each conversion takes eleven converter periods
// RL19 - clearing start bit mid-conversion aborts, result keeps old value
// RL20 - result bits outside the ten-bit value read zero
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"

module adccs_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_osc_clk,
  input wire logic core_sleep,
  input wire logic comp_above,
  output logic neg_ref_select,
  output logic pos_ref_select,
  output logic [15:0] pin_analog,
  output logic [3:0] channel_select,
  output logic sample_on,
  output logic [9:0] dac_code,
  output logic converter_enable,
  output logic conv_busy,
  output logic conv_done_flag
);

  adccs_pkg::adccs_top_s q, d;
  logic [7:0] res_high_q, res_high_d;
  logic [7:0] res_low_q, res_low_d;
  logic [15:0] pin_analog_next;
  logic [9:0] sar_code;
  logic sar_done;
  logic sar_abort;
  logic tad_tick;
  logic rc_sel;
  logic rc_rise;
  logic [5:0] div_last;
  logic [4:0] acq_tads;
  logic running;
  logic tick_ok;
  logic wr_en;
  logic rd_setup;
  localparam logic [7:0] ctrl_a_rst = `ADCCS_CTRL_A_RST;

  // divisor minus one for the synchronous sources, zero for rc
  always_comb begin
    case (q.cs)
      3'h0: div_last = 6'h01; // see RL6
      3'h1: div_last = 6'h07;
      3'h2: div_last = 6'h1f;
      3'h4: div_last = 6'h03;
      3'h5: div_last = 6'h0f;
      3'h6: div_last = 6'h3f;
      default: div_last = 6'h00;
    endcase
  end

  always_comb begin
    case (q.acq)
      3'h0: acq_tads = 5'd0; // see RL5
      3'h1: acq_tads = 5'd2;
      3'h2: acq_tads = 5'd4;
      3'h3: acq_tads = 5'd6;
      3'h4: acq_tads = 5'd8;
      3'h5: acq_tads = 5'd12;
      3'h6: acq_tads = 5'd16;
      default: acq_tads = 5'd20;
    endcase
  end

  assign rc_sel = (q.cs[1:0] == 2'b11); // see RL6
  assign rc_rise = q.rc_s2 && !q.rc_s3;
  // the system clock halts in sleep, so only the rc source may keep ticking
  assign tick_ok = !core_sleep || rc_sel; // see RL8
  assign running = (q.state == adccs_pkg::ST_ACQ) || (q.state == adccs_pkg::ST_CONV)
                   || (q.state == adccs_pkg::ST_GAP);
  assign tad_tick = running && tick_ok && (rc_sel ? rc_rise : (q.div_cnt == div_last));
  // enable dropped or start bit cleared while converting abandons the sar
  assign sar_abort = (q.state == adccs_pkg::ST_CONV) && (!q.en || !q.go); // see RL19

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pcfg
      // see RL3
      assign pin_analog_next[gi] = (q.port_ref[3:0] == 4'h0) ||
                                   (5'(gi) < (5'd15 - {1'b0, q.port_ref[3:0]}));
    end
  endgenerate

  assign wr_en = psel && penable && pwrite && q.pready;
  assign rd_setup = psel && !penable;

  always_comb begin
    d = q;
    res_high_d = res_high_q;
    res_low_d = res_low_q;
    d.sar_start = 1'b0;
    d.rc_s1 = rc_osc_clk;
    d.rc_s2 = q.rc_s1;
    d.rc_s3 = q.rc_s2;
    d.pready = 1'b1;
    d.pin_analog = pin_analog_next;

    if (running) begin
      d.div_cnt = (q.div_cnt == div_last) ? 6'h00 : q.div_cnt + 6'h01;
    end else begin
      d.div_cnt = 6'h00;
    end

    case (q.state)
      adccs_pkg::ST_IDLE: begin
        if (q.en && q.go) begin
          if (rc_sel) begin
            d.state = adccs_pkg::ST_RC_DLY;
            d.dly_cnt = 3'(`ADCCS_RC_DLY_CLKS - 1); // see RL7
          end else if (acq_tads == 5'd0) begin
            d.state = adccs_pkg::ST_CONV;
            d.sar_start = 1'b1;
          end else begin
            d.state = adccs_pkg::ST_ACQ;
            d.tad_cnt = acq_tads; // see RL13
          end
        end
      end
      adccs_pkg::ST_RC_DLY: begin
        if (!q.en || !q.go) begin
          d.state = adccs_pkg::ST_IDLE;
        end else if (q.dly_cnt == 3'h0) begin
          if (acq_tads == 5'd0) begin
            d.state = adccs_pkg::ST_CONV;
            d.sar_start = 1'b1;
          end else begin
            d.state = adccs_pkg::ST_ACQ;
            d.tad_cnt = acq_tads;
          end
        end else begin
          d.dly_cnt = q.dly_cnt - 3'h1; // see RL7
        end
      end
      adccs_pkg::ST_ACQ: begin
        if (!q.en || !q.go) begin
          d.state = adccs_pkg::ST_IDLE;
        end else if (tad_tick) begin
          if (q.tad_cnt == 5'd1) begin
            d.state = adccs_pkg::ST_CONV; // see RL13
            d.sar_start = 1'b1;
          end
          d.tad_cnt = q.tad_cnt - 5'd1;
        end
      end
      adccs_pkg::ST_CONV: begin
        if (!q.en) begin
          d.state = adccs_pkg::ST_IDLE;
        end else if (!q.go) begin
          d.state = adccs_pkg::ST_GAP; // see RL19
          d.tad_cnt = 5'(`ADCCS_GAP_TADS);
          // restart the divider so the gap spans two whole periods of a divided source
          d.div_cnt = 6'h00;
        end else if (sar_done) begin
          d.go = 1'b0; // see RL10
          d.flag = 1'b1;
          if (q.just) begin
            res_high_d = {6'h00, sar_code[9:8]}; // see RL4
            res_low_d = sar_code[7:0]; // see RL20
          end else begin
            res_high_d = sar_code[9:2];
            res_low_d = {sar_code[1:0], 6'h00}; // see RL20
          end
          d.state = adccs_pkg::ST_GAP; // see RL15
          d.tad_cnt = 5'(`ADCCS_GAP_TADS);
          d.div_cnt = 6'h00;
        end
      end
      adccs_pkg::ST_GAP: begin
        if (!q.en) begin
          d.state = adccs_pkg::ST_IDLE;
        end else if (tad_tick) begin
          if (q.tad_cnt == 5'd1) begin
            d.state = adccs_pkg::ST_IDLE; // see RL15
          end
          d.tad_cnt = q.tad_cnt - 5'd1;
        end
      end
      default: begin
        d.state = adccs_pkg::ST_IDLE;
      end
    endcase

    if (!q.en) begin
      d.go = 1'b0;
    end

    // bus writes take effect in the access phase
    if (wr_en) begin
      if (paddr == `ADCCS_ADDR_CTRL_A) begin
        d.en = pwdata[`ADCCS_CTL_EN_BIT];
        d.chan = pwdata[`ADCCS_CTL_CHAN_LSB +: 4]; // see RL17
        // start needs the converter already on, not switched on by this write
        if (!pwdata[`ADCCS_CTL_GO_BIT]) begin
          d.go = 1'b0; // see RL19
        end else if (q.en && pwdata[`ADCCS_CTL_EN_BIT]) begin
          d.go = 1'b1;
        end
      end else if (paddr == `ADCCS_ADDR_PORT_REF) begin
        d.port_ref = pwdata[5:0];
      end else if (paddr == `ADCCS_ADDR_FMT) begin
        d.just = pwdata[`ADCCS_FMT_JUST_BIT];
        d.acq = pwdata[`ADCCS_FMT_ACQ_LSB +: 3];
        d.cs = pwdata[`ADCCS_FMT_CS_LSB +: 3];
      end else if (paddr == `ADCCS_ADDR_RES_HIGH) begin
        res_high_d = pwdata[7:0];
      end else if (paddr == `ADCCS_ADDR_RES_LOW) begin
        res_low_d = pwdata[7:0];
      end else if (paddr == `ADCCS_ADDR_FLAG) begin
        // hardware completion in the same cycle wins over a clear
        d.flag = pwdata[`ADCCS_FLAG_DONE_BIT] || (sar_done && q.en && q.go &&
                 (q.state == adccs_pkg::ST_CONV));
      end
    end

    d.sample_on = d.en && ((d.state == adccs_pkg::ST_IDLE) ||
                           (d.state == adccs_pkg::ST_RC_DLY) ||
                           (d.state == adccs_pkg::ST_ACQ));

    // read data is captured in the setup phase and shown in the access phase
    if (rd_setup) begin
      d.prdata = 32'h0000_0000;
      d.pslverr = 1'b0;
      if (paddr == `ADCCS_ADDR_CTRL_A) begin
        d.prdata[5:0] = {q.chan, q.go, q.en}; // see RL16
      end else if (paddr == `ADCCS_ADDR_PORT_REF) begin
        d.prdata[5:0] = q.port_ref; // see RL16
      end else if (paddr == `ADCCS_ADDR_FMT) begin
        d.prdata[7:0] = {q.just, 1'b0, q.acq, q.cs}; // see RL16
      end else if (paddr == `ADCCS_ADDR_RES_HIGH) begin
        d.prdata[7:0] = res_high_q;
      end else if (paddr == `ADCCS_ADDR_RES_LOW) begin
        d.prdata[7:0] = res_low_q;
      end else if (paddr == `ADCCS_ADDR_FLAG) begin
        d.prdata[`ADCCS_FLAG_DONE_BIT] = q.flag;
      end else begin
        d.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q.state <= adccs_pkg::ST_IDLE; // see RL11
      q.en <= ctrl_a_rst[`ADCCS_CTL_EN_BIT];
      q.go <= ctrl_a_rst[`ADCCS_CTL_GO_BIT];
      q.chan <= ctrl_a_rst[`ADCCS_CTL_CHAN_LSB +: 4];
      q.port_ref <= `ADCCS_PORT_REF_RST;
      q.just <= `ADCCS_FMT_JUST_RST;
      q.acq <= `ADCCS_FMT_ACQ_RST;
      q.cs <= `ADCCS_FMT_CS_RST;
      q.flag <= 1'b0;
      q.div_cnt <= 6'h00;
      q.tad_cnt <= 5'h00;
      q.dly_cnt <= 3'h0;
      q.rc_s1 <= 1'b0;
      q.rc_s2 <= 1'b0;
      q.rc_s3 <= 1'b0;
      q.sar_start <= 1'b0;
      q.pin_analog <= 16'hffff;
      q.sample_on <= 1'b0;
      q.prdata <= 32'h0000_0000;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // the result pair has no reset so that it survives any reset untouched
  always_ff @(posedge clk) begin
    res_high_q <= res_high_d; // see RL12
    res_low_q <= res_low_d;
  end

  adccs_sar u_sar (
    .clk(clk),
    .rst_b(rst_b),
    .tad_tick(tad_tick),
    .start(q.sar_start),
    .abort(sar_abort),
    .comp_above(comp_above),
    .trial_code(sar_code),
    .done(sar_done)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign neg_ref_select = q.port_ref[`ADCCS_CFG_NEGREF_BIT]; // see RL1
  assign pos_ref_select = q.port_ref[`ADCCS_CFG_POSREF_BIT]; // see RL2
  assign pin_analog = q.pin_analog;
  assign channel_select = q.chan;
  assign sample_on = q.sample_on;
  assign dac_code = sar_code;
  assign converter_enable = q.en;
  assign conv_busy = q.go;
  assign conv_done_flag = q.flag;

endmodule
`default_nettype wire

// >>> bench/adccs_afe_model.sv
`timescale 1ns/10ps
`default_nettype none
module adccs_afe (
  input wire logic clk,
  input wire logic sample_on,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] level,
  output logic comp_above
);
  logic [9:0] held;
  // the hold capacitor follows the input only while the switch is closed
  always @(posedge clk) begin
    if (sample_on) held <= level;
  end
  assign comp_above = held >= dac_code;
endmodule
`default_nettype wire

// >>> bench/adccs_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"
module adccs_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic neg_ref_select,
  input wire logic pos_ref_select,
  input wire logic [15:0] pin_analog,
  input wire logic sample_on,
  input wire logic converter_enable,
  input wire logic conv_busy,
  input wire logic conv_done_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic acc, ctl_wr, mapped, rd_cfg;
  assign acc = psel && penable;
  assign ctl_wr = acc && pwrite && paddr == `ADCCS_ADDR_CTRL_A;
  assign mapped = paddr inside {`ADCCS_ADDR_CTRL_A, `ADCCS_ADDR_PORT_REF, `ADCCS_ADDR_FMT,
    `ADCCS_ADDR_RES_HIGH, `ADCCS_ADDR_RES_LOW, `ADCCS_ADDR_FLAG};
  assign rd_cfg = acc && !pwrite && paddr inside {`ADCCS_ADDR_PORT_REF, `ADCCS_ADDR_FMT};
  function automatic logic [15:0] dec(input logic [3:0] k);
    for (int i = 0; i < 16; i++) dec[i] = k == 4'h0 || i < 15 - k;
  endfunction
  sequence cfg_wr;
    acc && pready && pwrite && paddr == `ADCCS_ADDR_PORT_REF;
  endsequence
  // a software abort through the control write is excluded
  sequence conv_end;
    $fell(conv_busy) && converter_enable && !$past(ctl_wr);
  endsequence
  chk_apb_ready: assert property (acc |-> pready)
    else $error("pready low in access phase");
  chk_apb_unmapped: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong");
  chk_ref_neg: assert property (cfg_wr |=> neg_ref_select == $past(pwdata[5]))
    else $error("negative reference select wrong");
  chk_ref_pos: assert property (cfg_wr |=> pos_ref_select == $past(pwdata[4]))
    else $error("positive reference select wrong");
  chk_pin_decode: assert property (cfg_wr |=> ##1 pin_analog == dec($past(pwdata[3:0], 2)))
    else $error("pin decode wrong");
  chk_unimpl_zero: assert property (rd_cfg |-> prdata[31:8] == 24'h0 && !prdata[6])
    else $error("unimplemented bit set");
  chk_done_flag: assert property (conv_end |-> conv_done_flag)
    else $error("flag not set on completion");
  chk_gap_quiet: assert property (conv_end |-> !sample_on [*4])
    else $error("sampling resumed too early");
  chk_busy_en: assert property ($rose(conv_busy) |-> $past(converter_enable))
    else $error("start taken while disabled");
  chk_en_off: assert property (!converter_enable |=> !conv_busy)
    else $error("busy while disabled");
endmodule
bind adccs_top adccs_chk chk_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .neg_ref_select, .pos_ref_select, .pin_analog, .sample_on,
  .converter_enable, .conv_busy, .conv_done_flag);
`default_nettype wire

// >>> bench/tb_adc_config_and_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"
module tb_adc_config_and_sequencer;
  logic clk, rst_b, psel, penable, pwrite, rc_osc_clk, core_sleep, comp_above, pready;
  logic pslverr, neg_ref_select, pos_ref_select, sample_on, converter_enable, conv_busy;
  logic conv_done_flag, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pin_analog;
  logic [3:0] channel_select;
  logic [9:0] dac_code, ain_level;
  int err_count, checks_done, cyc, n;
  adccs_top dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rc_osc_clk, .core_sleep, .comp_above, .neg_ref_select, .pos_ref_select,
    .pin_analog, .channel_select, .sample_on, .dac_code, .converter_enable, .conv_busy,
    .conv_done_flag);
  adccs_afe afe_u (.clk, .sample_on, .dac_code, .level(ain_level), .comp_above);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // free-running internal oscillator, phase unrelated to clk
  initial begin
    rc_osc_clk = 1'b0;
    forever #83 rc_osc_clk = ~rc_osc_clk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [7:0] f);
    apb(1'b1, `ADCCS_ADDR_FMT, {24'h0, f});
    apb(1'b1, `ADCCS_ADDR_CTRL_A, 32'h3);
  endtask
  // e below zero skips the length check
  task automatic wait_done(input int e);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (conv_busy !== 1'b0 && n < 3000);
    if (e >= 0) chk("conv cycles", e, (n >= e && n <= e + 4) ? e : n);
    chk("conv finished", 32'h0, {31'h0, conv_busy});
    while (sample_on !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("sampling resumed", 32'h1, {31'h0, sample_on});
  endtask
  task automatic rd_res(input logic [31:0] h, input logic [31:0] l);
    apb(1'b0, `ADCCS_ADDR_RES_HIGH, 32'h0);
    chk("result high", h, rd);
    apb(1'b0, `ADCCS_ADDR_RES_LOW, 32'h0);
    chk("result low", l, rd);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped read", 32'h1, {rd[30:0], rd_err});
  endtask
  task automatic t_port;
    logic [31:0] v;
    logic [15:0] e;
    for (int k = 0; k < 16; k++) begin
      v = {26'h0, k[0], k[1], 4'(k)};
      for (int i = 0; i < 16; i++) e[i] = k == 0 || i < 15 - k;
      apb(1'b1, `ADCCS_ADDR_PORT_REF, v | 32'hc0);
      @(negedge clk);
      @(negedge clk);
      chk("pin_analog", {16'h0, e}, {16'h0, pin_analog});
      chk("refs", v[5:4], {neg_ref_select, pos_ref_select});
      apb(1'b0, `ADCCS_ADDR_PORT_REF, 32'h0);
      chk("port_ref read", v, rd);
    end
    apb(1'b1, `ADCCS_ADDR_PORT_REF, 32'h0);
  endtask
  task automatic t_clk;
    int dv[6] = '{2, 8, 32, 4, 16, 64};
    int cs[6] = '{0, 1, 2, 4, 5, 6};
    int aq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    apb(1'b1, `ADCCS_ADDR_FMT, 32'hff);
    apb(1'b0, `ADCCS_ADDR_FMT, 32'h0);
    chk("fmt read", 32'hbf, rd);
    apb(1'b1, `ADCCS_ADDR_CTRL_A, 32'h3f);
    apb(1'b0, `ADCCS_ADDR_CTRL_A, 32'h0);
    chk("start refused", 32'h3d, rd);
    chk("channel", 32'hf, {28'h0, channel_select});
    for (int i = 0; i < 6; i++) begin
      go(8'(cs[i]));
      wait_done(11 * dv[i]);
    end
    for (int k = 0; k < 8; k++) begin
      go(8'(k << 3));
      wait_done((aq[k] + 11) * 2);
    end
  endtask
  task automatic t_result;
    go(8'h80);
    wait_done(22);
    rd_res(32'h2, 32'hb5);
    go(8'h00);
    wait_done(22);
    rd_res(32'had, 32'h40);
    apb(1'b0, `ADCCS_ADDR_CTRL_A, 32'h0);
    chk("busy cleared", 32'h1, rd);
    apb(1'b0, `ADCCS_ADDR_FLAG, 32'h0);
    chk("done flag", 32'h1, rd);
    apb(1'b1, `ADCCS_ADDR_FLAG, 32'h0);
    apb(1'b0, `ADCCS_ADDR_FLAG, 32'h0);
    chk("flag cleared", 32'h0, rd);
  endtask
  task automatic t_rc;
    core_sleep <= 1'b1;
    go(8'h87);
    wait_done(-1);
    chk("rc in sleep", 32'h0, {31'h0, conv_busy});
    rd_res(32'h2, 32'hb5);
    go(8'h80);
    repeat (100) @(posedge clk);
    chk("stalled in sleep", 32'h1, {31'h0, conv_busy});
    core_sleep <= 1'b0;
    wait_done(-1);
    go(8'h83);
    wait_done(-1);
    chk("rc awake", 32'h0, {31'h0, conv_busy});
  endtask
  task automatic t_abort;
    ain_level <= 10'h155;
    go(8'h85);
    repeat (40) @(posedge clk);
    apb(1'b1, `ADCCS_ADDR_CTRL_A, 32'h1);
    wait_done(-1);
    rd_res(32'h2, 32'hb5);
    go(8'h85);
    repeat (40) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("off after reset", 32'h0, {converter_enable, conv_busy});
    rd_res(32'h2, 32'hb5);
    apb(1'b0, `ADCCS_ADDR_FMT, 32'h0);
    chk("fmt after reset", 32'h0, rd);
  endtask
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    core_sleep = 1'b0;
    ain_level = 10'h2b5;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_port;
    t_clk;
    t_result;
    t_rc;
    t_abort;
    tally_and_finish;
  end
endmodule
`default_nettype wire
